// *** dv/dia_host_model.sv ***
// Purpose: Host processor that acknowledges a pending interrupt request.
// Assumes: Request and acknowledge pins are active low.
// Notes:   Holds the acknowledge pin low for six clocks per cycle.
`timescale 1ns/1ps
module dia_host_model
(
    // Clock.
    input wire logic CLK,
    // Pins.
    input wire logic irq_n,
    input wire logic go,
    output logic     ack_n
);
    logic [3:0] cnt_q = 4'h0;

    always @(posedge CLK)
        cnt_q <= cnt_q != 4'h0 ? cnt_q - 4'h1 : (go && !irq_n ? 4'h9 : 4'h0);
    assign ack_n = !(cnt_q > 4'h3);
endmodule

// *** dv/dia_properties.sv ***
// Purpose: Port timing checks for the interrupt arbiter.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes:   Bound to every instance of the arbiter top.
`timescale 1ns/1ps
module dia_props
(
    // Clock and reset.
    input wire logic        CLK,
    input wire logic        SYS_RST,
    // APB.
    input wire logic [11:0] PADDR,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Interrupt pins and context.
    input wire logic        INTERRUPT_ACK_LINE_N,
    input wire logic        VECTOR_OE,
    input wire logic [2:0]  CTX_CHAN,
    input wire logic [3:0]  CTX_TYPE
);
    logic [1:0] upd_q;
    logic [3:0] ack_age_q;

    // Recent update commands and clocks since the acknowledge pin was last low.
    always_ff @(posedge CLK or posedge SYS_RST)
        if (SYS_RST)
        begin
            upd_q     <= 2'b00;
            ack_age_q <= 4'hF;
        end
        else
        begin
            upd_q     <= {upd_q[0], PSEL && PENABLE && PREADY && PWRITE
                          && PADDR == dia_pkg::ADDR_CUR};
            ack_age_q <= !INTERRUPT_ACK_LINE_N ? 4'h0
                         : (ack_age_q == 4'hF ? ack_age_q : ack_age_q + 4'h1);
        end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    property p_apb_wait;
        PSEL && PENABLE && !PREADY |=> PREADY;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("no answer after one wait state");
    property p_ready_pulse;
        PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_idle_ready;
        !PSEL |-> !PREADY;
    endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("ready without select");
    property p_err_ready;
        PSLVERR |-> PREADY && PRDATA == 32'h0;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready or data zero");
    property p_data_hold;
        !$stable(PRDATA) |-> PREADY;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("read data moved outside a transfer");
    property p_ctx_hold;
        !$stable({CTX_CHAN, CTX_TYPE}) |-> upd_q != 2'b00 || ack_age_q < 4'h8;
    endproperty
    a_ctx_hold: assert property (p_ctx_hold) else $error("context changed without capture");
    property p_vec_ack;
        VECTOR_OE |-> ack_age_q < 4'h6;
    endproperty
    a_vec_ack: assert property (p_vec_ack) else $error("vector driven outside acknowledge");
    property p_ctx_type;
        !(CTX_TYPE inside {4'hA, 4'hE, 4'hF});
    endproperty
    a_ctx_type: assert property (p_ctx_type) else $error("undefined source type captured");
    property p_ctx_chan;
        CTX_CHAN <= 3'h1;
    endproperty
    a_ctx_chan: assert property (p_ctx_chan) else $error("channel code out of range");

    c_vec: cover property ($rose(VECTOR_OE));
    c_err: cover property (PSLVERR);
    c_upd: cover property (upd_q[0]);
endmodule

bind dia_top dia_props props_u
(
    .CLK(CLK), .SYS_RST(SYS_RST), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .INTERRUPT_ACK_LINE_N(INTERRUPT_ACK_LINE_N), .VECTOR_OE(VECTOR_OE),
    .CTX_CHAN(CTX_CHAN), .CTX_TYPE(CTX_TYPE)
);

// *** dv/dia_top_tb_top.sv ***
// Purpose: Self-checking bench for the interrupt arbiter.
// Assumes: APB answers after one wait state; bids settle within 53 clocks.
// Notes:   Captures are taken by update command and by host acknowledge.
`timescale 1ns/1ps
module dia_top_tb_top;
    logic        CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [3:0]  rxa = 4'h0;
    logic [3:0]  rxb = 4'h0;
    logic [3:0]  txa = 4'h0;
    logic [2:0]  err = 3'h0;
    logic [4:0]  ev = 5'h00;
    logic        go = 1'b0;
    logic        ack_n, prdy, slv_o, irq_n, voe, slv;
    logic [31:0] prd, q;
    logic [7:0]  vec;
    logic [2:0]  cch;
    logic [3:0]  cty;
    int          fails = 0;
    int          check_count = 0;
    int          cyc = 0;

    always #12.5 CLK = ~CLK;

    dia_top dut_u
    (
        .CLK(CLK), .SYS_RST(SYS_RST), .PADDR(padr), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(slv_o),
        .RX_FILL_CNT_A(rxa), .RX_FILL_CNT_B(rxb), .RX_PARITY_ERR({1'b0, err[0]}),
        .RX_FRAMING_ERR({1'b0, err[1]}), .RX_OVERRUN_ERR({1'b0, err[2]}),
        .TX_EMPTY_CNT_A(txa), .TX_EMPTY_CNT_B(4'h0), .BREAK_CHANGE({1'b0, ev[0]}),
        .IO_CHANGE({1'b0, ev[1]}), .XON_XOFF_EVENT({1'b0, ev[2]}),
        .ADDR_MATCH({1'b0, ev[3]}), .COUNTER_TIMER(ev[4]), .INTERRUPT_ACK_LINE_N(ack_n),
        .INTERRUPT_REQUEST_LINE_N(irq_n), .VECTOR_DATA(vec), .VECTOR_OE(voe),
        .CTX_CHAN(cch), .CTX_TYPE(cty)
    );
    dia_host_model host_u (.CLK(CLK), .irq_n(irq_n), .go(go), .ack_n(ack_n));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        psel <= 1'b1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge CLK);
        pen <= 1'b1;
        @(posedge CLK);
        while (prdy !== 1'b1)
            @(posedge CLK);
        q = prd;
        slv = slv_o;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // Arbitration reaches the request line within 53 clocks of a source change.
    task automatic settle(input logic exp);
        repeat (60) @(posedge CLK);
        chk(irq_n, exp);
    endtask

    task automatic cap(input logic [31:0] bid);
        wr(dia_pkg::ADDR_CUR, 32'h0);
        rd(dia_pkg::ADDR_CUR, bid);
        chk(cty, bid[6:3]);
        chk(cch, bid[2:0]);
    endtask

    task automatic t_reset();
        chk(irq_n, 1'b1);
        chk(cty, 4'h0);
        rd(dia_pkg::ADDR_IVR, 32'h0F);
        apb(1'b0, 12'hFFC, 32'h0);
        chk(slv, 1'b1);
    endtask

    task automatic t_rx();
        wr(dia_pkg::ADDR_MSK, 32'h1);
        rxa <= 4'h1;
        settle(1'b0);
        cap(32'h008);
        rxa <= 4'h3;
        settle(1'b0);
        cap(32'h108);
        ev <= 5'h01;
        settle(1'b0);
        cap(32'h108);
        for (int i = 0; i < 3; i++)
        begin
            err <= 3'h1 << i;
            settle(1'b0);
            cap(32'h128);
        end
        err <= 3'h0;
        ev  <= 5'h00;
    endtask

    task automatic t_tie();
        wr(dia_pkg::ADDR_MSK, 32'h41);
        rxb <= 4'h3;
        settle(1'b0);
        cap(32'h109);
        rd(dia_pkg::ADDR_GLB_CHAN, 32'h1);
        rd(dia_pkg::ADDR_GLB_TYPE, 32'h09);
        rd(dia_pkg::ADDR_GLB_BCNT, 32'h3);
        wr(dia_pkg::ADDR_CTL, 32'h180);
        go <= 1'b1;
        for (int n = 0; n < 20 && voe !== 1'b1; n++)
            @(posedge CLK);
        chk(voe, 1'b1);
        chk(vec, 8'h09);
        go  <= 1'b0;
        rxa <= 4'h8;
        settle(1'b0);
        rd(dia_pkg::ADDR_CUR, 32'h109);
        rxa <= 4'h0;
        rxb <= 4'h0;
        settle(1'b1);
    endtask

    task automatic t_tx();
        wr(dia_pkg::ADDR_MSK, 32'h2);
        txa <= 4'h8;
        wr(dia_pkg::ADDR_CTL, 32'h40);
        settle(1'b1);
        wr(dia_pkg::ADDR_CTL, 32'h38);
        settle(1'b1);
        wr(dia_pkg::ADDR_CTL, 32'h37);
        settle(1'b0);
        cap(32'h1C0);
        rd(dia_pkg::ADDR_GLB_BCNT, 32'h8);
        // Threshold zero, so only the level select can keep the request high.
        wr(dia_pkg::ADDR_CTL, 32'h0);
        wr(dia_pkg::ADDR_MODE0_A, 32'h30);
        txa <= 4'h7;
        settle(1'b1);
        txa <= 4'h8;
        settle(1'b0);
        txa <= 4'h0;
    endtask

    task automatic t_lvl();
        logic [3:0] lvl [4] = '{dia_pkg::LVL_ANY, dia_pkg::LVL_HALF,
                                dia_pkg::LVL_3Q, dia_pkg::LVL_FULL};
        wr(dia_pkg::ADDR_MSK, 32'h1);
        for (int s = 0; s < 4; s++)
        begin
            wr(dia_pkg::ADDR_MODE2_A, 32'(s) << 2);
            rxa <= lvl[s] - 4'h1;
            settle(1'b1);
            rxa <= lvl[s];
            settle(1'b0);
        end
        rxa <= 4'h0;
        wr(dia_pkg::ADDR_MODE2_A, 32'h0);
    endtask

    task automatic t_ev();
        logic [3:0] ty [5] = '{dia_pkg::TYPE_BREAK, dia_pkg::TYPE_COS, dia_pkg::TYPE_XON,
                               dia_pkg::TYPE_ADDR, dia_pkg::TYPE_CT};
        int         lsb [5] = '{0, 3, 6, 9, dia_pkg::PRIO_CT_LSB};
        int         msk [5] = '{2, 3, 4, 5, 12};
        for (int i = 0; i < 5; i++)
        begin
            wr(dia_pkg::ADDR_MSK, 32'h1 << msk[i]);
            wr(dia_pkg::ADDR_PRIO, 32'h5 << lsb[i]);
            ev <= 5'h01 << i;
            settle(1'b0);
            cap({22'h0, 3'h5, ty[i], 3'h0});
        end
    endtask

    task automatic t_mask();
        wr(dia_pkg::ADDR_MSK, 32'h1FFF);
        rxa <= 4'h2;
        ev  <= 5'h1F;
        settle(1'b0);
        wr(dia_pkg::ADDR_MSK, 32'h0);
        settle(1'b1);
        cap(32'h0);
        // An empty capture clears the substituted vector bits.
        wr(dia_pkg::ADDR_IVR, 32'hFF);
        wr(dia_pkg::ADDR_CTL, 32'h180);
        repeat (2) @(posedge CLK);
        chk(vec, 8'hE0);
    endtask

    task automatic final_report();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            fails++;
            final_report();
        end
    end

    initial
    begin
        repeat (10) @(posedge CLK);
        SYS_RST <= 1'b0;
        t_reset();
        t_rx();
        t_tie();
        t_tx();
        t_lvl();
        t_ev();
        t_mask();
        final_report();
    end
endmodule

// *** rtl/dia_pkg.sv ***
// Purpose: Shared constants and types for the dual-channel interrupt arbiter.
// Assumes: APB register access with 32-bit data; eight-entry receive and transmit FIFOs.
// Notes:   Byte addresses are word aligned; unused bits read as zero.
package dia_pkg;
    // Register byte addresses.
    localparam logic [11:0] ADDR_CTL      = 12'h000;
    localparam logic [11:0] ADDR_MSK      = 12'h004;
    localparam logic [11:0] ADDR_MODE0_A  = 12'h008;
    localparam logic [11:0] ADDR_MODE0_B  = 12'h00C;
    localparam logic [11:0] ADDR_MODE2_A  = 12'h010;
    localparam logic [11:0] ADDR_MODE2_B  = 12'h014;
    localparam logic [11:0] ADDR_PRIO     = 12'h018;
    localparam logic [11:0] ADDR_IVR      = 12'h01C;
    localparam logic [11:0] ADDR_CUR      = 12'h020;
    localparam logic [11:0] ADDR_STATUS   = 12'h024;
    localparam logic [11:0] ADDR_GLB_BASE = 12'h040;
    localparam logic [11:0] ADDR_GLB_LAST = 12'h088;
    localparam logic [11:0] ADDR_GLB_BCNT = 12'h040;
    localparam logic [11:0] ADDR_GLB_CHAN = 12'h044;
    localparam logic [11:0] ADDR_GLB_TYPE = 12'h048;

    // Field positions and widths.
    localparam int CTL_THR_MSB   = 6;
    localparam int CTL_VMOD_TYPE = 7;
    localparam int CTL_VMOD_CHAN = 8;
    localparam int MODE0_TX_LSB  = 4;
    localparam int MODE2_RX_LSB  = 2;
    localparam int SRC_PER_CHAN  = 6;
    localparam int NUM_CHAN      = 2;
    localparam int NUM_SRC       = 13;
    localparam int PRIO_CT_LSB   = 24;

    // Reset values.
    localparam logic [8:0]  CTL_RESET  = 9'h000;
    localparam logic [12:0] MSK_RESET  = 13'h0000;
    localparam logic [7:0]  IVR_RESET  = 8'h0F;
    localparam logic [26:0] PRIO_RESET = 27'h0000000;

    // Source type codes in bid bits 6:3.
    localparam logic [3:0] TYPE_RX      = 4'h1;
    localparam logic [3:0] TYPE_RX_ERR  = 4'h5;
    localparam logic [3:0] TYPE_TX      = 4'h0;
    localparam logic [3:0] TYPE_BREAK   = 4'h2;
    localparam logic [3:0] TYPE_COS     = 4'h6;
    localparam logic [3:0] TYPE_XON     = 4'h7;
    localparam logic [3:0] TYPE_ADDR    = 4'hB;
    localparam logic [3:0] TYPE_CT      = 4'h3;

    // FIFO level thresholds for the bid level selects.
    localparam logic [3:0] LVL_ANY  = 4'h1;
    localparam logic [3:0] LVL_HALF = 4'h4;
    localparam logic [3:0] LVL_3Q   = 4'h6;
    localparam logic [3:0] LVL_FULL = 4'h8;

    // Arbitration cycle length in crystal clocks.
    localparam logic [4:0] ARB_CYCLES = 5'h1A;

    typedef enum logic [1:0] {
        ARB_SNAP = 2'b00,
        ARB_SCAN = 2'b01,
        ARB_HOLD = 2'b10
    } dia_arb_t;
endpackage

// *** rtl/dia_top.sv ***
// Purpose: Interrupt bidding, threshold compare, winner capture and vector for a dual UART.
// Assumes: CLK is the crystal clock; FIFO counts and status flags come from logic on CLK.
// Notes:   The acknowledge pin is synchronised; APB answers with one wait state.
// Contract
// - Bid bits 6:3 carry the source type code, bit 6 being count for a transmitter; a zero bid means nothing active, or transmitter A with one empty entry.
// - Parity, framing or overrun make a receiver bid with-error; break does not.
// - Captured bits 4:0 modify the vector and form the type register.
// - Channel A is coded 0, B is 1, so B wins ties.
// - Transmitter count sits one bit lower in the bid than receiver count.
// - A threshold with its top bit set keeps every transmitter silent.
// - Level selects keep a receiver or transmitter out of bidding.
// - Only mask-enabled sources bid, raise a request or get captured.
// - A bid joins channel, type code, and either FIFO level or a programmed value.
// - Request line is low only while an enabled bid exceeds the threshold.
// - Acknowledge or update captures the prevailing winner into the capture register.
// - Arbitration runs on the crystal clock, a new winner every 26 cycles.
// - Bids changing mid-cycle are judged in the next arbitration cycle.
// - Non-FIFO sources take their high bid bits from a programmed field.
// - Receiver bid grows with filled entries, transmitter bid with empty ones.
// - Acknowledge returns the vector, optionally with type and channel substituted.
// - The capture register holds until the next acknowledge or update.
// - Capture with no bid over threshold loads all zeros.
// - After a capture with nothing pending, modified vector bits read zero.
// - Nineteen global registers are routed by the captured context.
// - Global info registers give byte count, channel and type from context.
// - Threshold bit 6 aligns with bid bit 9; channel bits are not compared.
// - Level selects: not empty, half, three quarters, full (or empty counterparts).
`timescale 1ns/1ps
module dia_top
(
    // Clock and reset.
    input  wire  logic        CLK,
    input  wire  logic        SYS_RST,
    // APB slave.
    input  wire  logic [11:0] PADDR,
    input  wire  logic        PSEL,
    input  wire  logic        PENABLE,
    input  wire  logic        PWRITE,
    input  wire  logic [31:0] PWDATA,
    output logic       [31:0] PRDATA,
    output logic              PREADY,
    output logic              PSLVERR,
    // Receiver status per channel, bit 0 is channel A.
    input  wire  logic [3:0]  RX_FILL_CNT_A,
    input  wire  logic [3:0]  RX_FILL_CNT_B,
    input  wire  logic [1:0]  RX_PARITY_ERR,
    input  wire  logic [1:0]  RX_FRAMING_ERR,
    input  wire  logic [1:0]  RX_OVERRUN_ERR,
    // Transmitter status per channel.
    input  wire  logic [3:0]  TX_EMPTY_CNT_A,
    input  wire  logic [3:0]  TX_EMPTY_CNT_B,
    // Event sources, per channel except the single counter timer, held high while pending.
    input  wire  logic [1:0]  BREAK_CHANGE,
    input  wire  logic [1:0]  IO_CHANGE,
    input  wire  logic [1:0]  XON_XOFF_EVENT,
    input  wire  logic [1:0]  ADDR_MATCH,
    input  wire  logic        COUNTER_TIMER,
    // Host interrupt pins.
    input  wire  logic        INTERRUPT_ACK_LINE_N,
    output logic              INTERRUPT_REQUEST_LINE_N,
    output logic       [7:0]  VECTOR_DATA,
    output logic              VECTOR_OE,
    // Current interrupt context for global register routing.
    output logic       [2:0]  CTX_CHAN,
    output logic       [3:0]  CTX_TYPE
);

    typedef struct packed {
        logic [8:0]                   ctl;
        logic [12:0]                  msk;
        logic [1:0][1:0]              tx_sel;
        logic [1:0][1:0]              rx_sel;
        logic [26:0]                  prio;
        logic [7:0]                   ivr;
        logic [11:0]                  cur;
        dia_pkg::dia_arb_t            arb;
        logic [4:0]                   cnt;
        logic [dia_pkg::NUM_SRC-1:0][11:0] snap;
        logic [11:0]                  best;
        logic [11:0]                  win;
        logic                         ack_s1;
        logic                         ack_s2;
        logic                         ack_prev;
        logic                         irq_n;
        logic [7:0]                   vect;
        logic                         vect_oe;
        logic                         pready;
        logic [31:0]                  prdata;
        logic                         pslverr;
    } dia_state_t;

    dia_state_t                        s;
    dia_state_t                        d;
    logic [dia_pkg::NUM_SRC-1:0][11:0] live;
    logic [1:0][3:0]                   rx_cnt;
    logic [1:0][3:0]                   tx_cnt;

    assign rx_cnt = {RX_FILL_CNT_B, RX_FILL_CNT_A};
    assign tx_cnt = {TX_EMPTY_CNT_B, TX_EMPTY_CNT_A};

    // Maps a level select code onto the count at which bidding starts.
    function automatic logic [3:0] level_of(input logic [1:0] sel);
        logic [3:0] lvl;
        unique case (sel)
            2'h0: lvl = dia_pkg::LVL_ANY;
            2'h1: lvl = dia_pkg::LVL_HALF;
            2'h2: lvl = dia_pkg::LVL_3Q;
            2'h3: lvl = dia_pkg::LVL_FULL;
        endcase
        return lvl;
    endfunction

    // Live bids per channel; a masked or inactive source bids zero.
    for (genvar ch = 0; ch < dia_pkg::NUM_CHAN; ch++)
    begin : g_chan
        localparam int B = ch * dia_pkg::SRC_PER_CHAN;
        localparam int P = ch * 12;
        logic [2:0] chan;
        logic [3:0] rx_m1;
        logic [3:0] tx_m1;
        logic       rx_err;
        logic       rx_on;
        logic       tx_on;
        assign chan   = 3'(ch);
        assign rx_m1  = rx_cnt[ch] - 4'h1;
        assign tx_m1  = tx_cnt[ch] - 4'h1;
        assign rx_err = RX_PARITY_ERR[ch] | RX_FRAMING_ERR[ch] | RX_OVERRUN_ERR[ch];
        assign rx_on  = (rx_cnt[ch] != 4'h0)
                        && (rx_cnt[ch] >= level_of(s.rx_sel[ch]));
        assign tx_on  = (tx_cnt[ch] != 4'h0)
                        && (tx_cnt[ch] >= level_of(s.tx_sel[ch]));
        // Receiver count at bits 9:7, transmitter count one lower at 8:6.
        assign live[B+0] = (s.msk[B+0] && rx_on)
                           ? {2'h0, rx_m1[2:0],
                              (rx_err ? dia_pkg::TYPE_RX_ERR : dia_pkg::TYPE_RX), chan}
                           : 12'h000;
        assign live[B+1] = (s.msk[B+1] && tx_on)
                           ? {3'h0, tx_m1[2:0], 3'h0, chan}
                           : 12'h000;
        assign live[B+2] = (s.msk[B+2] && BREAK_CHANGE[ch])
                           ? {2'h0, s.prio[P+2:P+0], dia_pkg::TYPE_BREAK, chan}
                           : 12'h000;
        assign live[B+3] = (s.msk[B+3] && IO_CHANGE[ch])
                           ? {2'h0, s.prio[P+5:P+3], dia_pkg::TYPE_COS, chan}
                           : 12'h000;
        assign live[B+4] = (s.msk[B+4] && XON_XOFF_EVENT[ch])
                           ? {2'h0, s.prio[P+8:P+6], dia_pkg::TYPE_XON, chan}
                           : 12'h000;
        assign live[B+5] = (s.msk[B+5] && ADDR_MATCH[ch])
                           ? {2'h0, s.prio[P+11:P+9], dia_pkg::TYPE_ADDR, chan}
                           : 12'h000;
    end

    assign live[dia_pkg::NUM_SRC-1] = (s.msk[dia_pkg::NUM_SRC-1] && COUNTER_TIMER)
                                      ? {2'h0, s.prio[dia_pkg::PRIO_CT_LSB+2:dia_pkg::PRIO_CT_LSB],
                                         dia_pkg::TYPE_CT, 3'h0}
                                      : 12'h000;

    always_comb
    begin
        logic       rd_req;
        logic       wr_acc;
        logic       ack_fall;
        logic       upd;
        logic       pend;
        logic [7:0] v;
        logic [3:0] gcnt;
        d        = s;
        rd_req   = PSEL && PENABLE && !s.pready;
        wr_acc   = PSEL && PENABLE && s.pready && PWRITE;
        ack_fall = s.ack_prev && !s.ack_s2;
        upd      = wr_acc && (PADDR == dia_pkg::ADDR_CUR);
        v        = s.ivr;
        // Threshold bit 6 meets bid bit 9; channel bits 2:0 stay out.
        pend     = s.win[9:3] > s.ctl[dia_pkg::CTL_THR_MSB:0];
        gcnt     = 4'h0;

        d.ack_s1   = INTERRUPT_ACK_LINE_N;
        d.ack_s2   = s.ack_s1;
        d.ack_prev = s.ack_s2;

        // Snapshot, serial scan of the snapshot, then idle to fill 26 cycles.
        unique case (s.arb)
            dia_pkg::ARB_SNAP:
            begin
                d.snap = live;
                d.best = 12'h000;
                d.cnt  = 5'h00;
                d.arb  = dia_pkg::ARB_SCAN;
            end
            dia_pkg::ARB_SCAN:
            begin
                if (s.snap[s.cnt[3:0]] > s.best)
                begin
                    d.best = s.snap[s.cnt[3:0]];
                end
                d.cnt = s.cnt + 5'h01;
                if (s.cnt == 5'(dia_pkg::NUM_SRC - 1))
                begin
                    d.arb = dia_pkg::ARB_HOLD;
                end
            end
            dia_pkg::ARB_HOLD:
            begin
                d.cnt = s.cnt + 5'h01;
                if (s.cnt == dia_pkg::ARB_CYCLES - 5'h02)
                begin
                    d.win = s.best;
                    d.arb = dia_pkg::ARB_SNAP;
                end
            end
            default:
            begin
                d.arb = dia_pkg::ARB_SNAP;
            end
        endcase

        d.irq_n = !pend;

        if (ack_fall || upd)
        begin
            d.cur = pend ? s.win : 12'h000;
        end

        if (s.ctl[dia_pkg::CTL_VMOD_TYPE])
        begin
            v[4:3] = s.cur[4:3];
        end
        if (s.ctl[dia_pkg::CTL_VMOD_CHAN])
        begin
            v[2:0] = s.cur[2:0];
        end
        d.vect    = v;
        d.vect_oe = !s.ack_s2 && !s.ack_prev;

        // Byte count of the interrupting FIFO from the captured context.
        if (s.cur[5:3] == dia_pkg::TYPE_RX[2:0] || s.cur[5:3] == dia_pkg::TYPE_RX_ERR[2:0])
        begin
            gcnt = {1'b0, s.cur[9:7]} + 4'h1;
        end
        // A transmitter's bit 6 carries count, so only bits 4:3 identify it.
        else if (s.cur[4:3] == dia_pkg::TYPE_TX[1:0] && s.cur != 12'h000)
        begin
            gcnt = {1'b0, s.cur[8:6]} + 4'h1;
        end

        d.pready  = rd_req;
        d.pslverr = 1'b0;
        if (rd_req)
        begin
            d.prdata = 32'h0000_0000;
            unique case (PADDR)
                dia_pkg::ADDR_CTL:     d.prdata = {23'h0, s.ctl};
                dia_pkg::ADDR_MSK:     d.prdata = {19'h0, s.msk};
                dia_pkg::ADDR_MODE0_A: d.prdata = {26'h0, s.tx_sel[0], 4'h0};
                dia_pkg::ADDR_MODE0_B: d.prdata = {26'h0, s.tx_sel[1], 4'h0};
                dia_pkg::ADDR_MODE2_A: d.prdata = {28'h0, s.rx_sel[0], 2'h0};
                dia_pkg::ADDR_MODE2_B: d.prdata = {28'h0, s.rx_sel[1], 2'h0};
                dia_pkg::ADDR_PRIO:    d.prdata = {5'h0, s.prio};
                dia_pkg::ADDR_IVR:     d.prdata = {24'h0, s.ivr};
                dia_pkg::ADDR_CUR:     d.prdata = {20'h0, s.cur};
                dia_pkg::ADDR_STATUS:  d.prdata = {19'h0, pend, s.win};
                dia_pkg::ADDR_GLB_BCNT: d.prdata = {28'h0, gcnt};
                dia_pkg::ADDR_GLB_CHAN: d.prdata = {29'h0, s.cur[2:0]};
                dia_pkg::ADDR_GLB_TYPE: d.prdata = {27'h0, s.cur[4:0]};
                default:
                begin
                    // Remaining global slots belong to routed resources outside this block.
                    if (PADDR < dia_pkg::ADDR_GLB_BASE || PADDR > dia_pkg::ADDR_GLB_LAST
                        || PADDR[1:0] != 2'h0)
                    begin
                        d.pslverr = 1'b1;
                    end
                end
            endcase
        end

        if (wr_acc)
        begin
            unique case (PADDR)
                dia_pkg::ADDR_CTL:     d.ctl       = PWDATA[8:0];
                dia_pkg::ADDR_MSK:     d.msk       = PWDATA[12:0];
                dia_pkg::ADDR_MODE0_A: d.tx_sel[0] = PWDATA[dia_pkg::MODE0_TX_LSB+:2];
                dia_pkg::ADDR_MODE0_B: d.tx_sel[1] = PWDATA[dia_pkg::MODE0_TX_LSB+:2];
                dia_pkg::ADDR_MODE2_A: d.rx_sel[0] = PWDATA[dia_pkg::MODE2_RX_LSB+:2];
                dia_pkg::ADDR_MODE2_B: d.rx_sel[1] = PWDATA[dia_pkg::MODE2_RX_LSB+:2];
                dia_pkg::ADDR_PRIO:    d.prio      = PWDATA[26:0];
                dia_pkg::ADDR_IVR:     d.ivr       = PWDATA[7:0];
                default:               d.ivr       = s.ivr;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            s          <= '0;
            s.ctl      <= dia_pkg::CTL_RESET;
            s.msk      <= dia_pkg::MSK_RESET;
            s.prio     <= dia_pkg::PRIO_RESET;
            s.ivr      <= dia_pkg::IVR_RESET;
            s.arb      <= dia_pkg::ARB_SNAP;
            s.ack_s1   <= 1'b1;
            s.ack_s2   <= 1'b1;
            s.ack_prev <= 1'b1;
            s.irq_n    <= 1'b1;
        end
        else
        begin
            s <= d;
        end
    end

    assign PRDATA                   = s.prdata;
    assign PREADY                   = s.pready;
    assign PSLVERR                  = s.pslverr;
    assign INTERRUPT_REQUEST_LINE_N = s.irq_n;
    assign VECTOR_DATA              = s.vect;
    assign VECTOR_OE                = s.vect_oe;
    assign CTX_CHAN                 = s.cur[2:0];
    assign CTX_TYPE                 = s.cur[6:3];

endmodule
